// *** olisr_map.svh ***
// Purpose: address map, defaults, field positions and timing of olisr
// Assumes: byte wide registers, 200 MHz reference clock
// Notes  : cycle counts are derived from the times and the clock rate
`ifndef OLISR_MAP_SVH
`define OLISR_MAP_SVH
// ==========================================================
// timing
`define OLISR_CLK_KHZ  200000
`define OLISR_RST_MS   20
`define OLISR_TICK_MS  1000
`define OLISR_RST_CYC  (`OLISR_RST_MS * `OLISR_CLK_KHZ)
`define OLISR_TICK_CYC (`OLISR_TICK_MS * `OLISR_CLK_KHZ)
// ==========================================================
// write addresses
`define OLISR_WA_CTRL  4'h0
`define OLISR_WA_LAMP  4'h1
`define OLISR_WA_AL_H  4'h2
`define OLISR_WA_AL_M  4'h3
`define OLISR_WA_AL_S  4'h4
`define OLISR_WA_WT_H  4'h5
`define OLISR_WA_WT_M  4'h6
`define OLISR_WA_WT_S  4'h7
`define OLISR_WA_IMP   4'h8
`define OLISR_WA_LAST  8'h08
// ==========================================================
// read sequence positions
`define OLISR_RI_STAT  4'h0
`define OLISR_RI_PREV  4'h1
`define OLISR_RI_NEW   4'h2
`define OLISR_RI_LAST  4'h8
// ==========================================================
// defaults and limits
`define OLISR_DEF_STAT 8'h02
`define OLISR_DEF_CTRL 8'h03
`define OLISR_DEF_LAMP 8'h04
`define OLISR_DEF_IMP  8'h03
`define OLISR_DEF_AL_H 5'h1F
`define OLISR_DEF_AL_X 6'h3F
`define OLISR_HR_LAST  5'h17
`define OLISR_MS_LAST  6'h3B
// ==========================================================
// field positions
`define OLISR_CTRL_PWR 1
`define OLISR_LAMP_HI  7
`define OLISR_LAMP_FN  6
`endif

// *** olisr_pkg.sv ***
// Purpose: types shared by the olisr design
// Assumes: one-hot state codes
// Notes  : none
`default_nettype none
package olisr_pkg;
  // ==========================================================
  // operating modes of the supervisor
  typedef enum logic [3:0] {
    M_CLEAR = 4'h1,
    M_PULSE = 4'h2,
    M_RUN   = 4'h4,
    M_OSCF  = 4'h8
  } olisr_mode_t;
  // ==========================================================
  // serial slave states
  typedef enum logic [8:0] {
    L_IDLE = 9'h001,
    L_ADDR = 9'h002,
    L_AACK = 9'h004,
    L_WADR = 9'h008,
    L_WDAT = 9'h010,
    L_DACK = 9'h020,
    L_RDAT = 9'h040,
    L_RACK = 9'h080,
    L_IGN  = 9'h100
  } olisr_link_t;
endpackage : olisr_pkg
`default_nettype wire

// *** olisr_top.sv ***
// Purpose: serial slave port and register map of an on/off supervisor
// Assumes: SCL/SDA oversampled on LINK_CLK_I; registers on REF_CLK_I
// Notes  : one toggle handshake carries each byte access between domains
`timescale 1ns/10ps
`default_nettype none
`include "olisr_map.svh"
module olisr_top
  import olisr_pkg::*;
#(
  parameter logic [6:0]  DEV_SEL  = 7'h2A, // arbitrary select code
  parameter int unsigned RST_CYC  = `OLISR_RST_CYC,
  parameter int unsigned TICK_CYC = `OLISR_TICK_CYC
) (
  input  wire logic       REF_CLK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic       LINK_CLK_I,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output var  logic       SDA_O,
  output var  logic       SDA_OE_O,
  input  wire logic       SYSTEM_CLEAR_N_I,
  input  wire logic [7:0] SENSE_IN_I,
  input  wire logic       OSC_FAIL_I,
  input  wire logic       HALF_SUPPLY_I,
  input  wire logic       WDOG_RST_EVT_I,
  input  wire logic       LINK_MISS_EVT_I,
  input  wire logic       LV_TIMER_EVT_I,
  output var  logic       RESET_PULSE_OUT_O,
  output var  logic       RESET_PULSE_OUT_OE_O,
  output var  logic       POWER_HOLD_O,
  output var  logic       LAMP_OUT_O,
  output var  logic       CHANGE_FLAG_N_O,
  output var  logic       CHANGE_FLAG_N_OE_O
);
  // ==========================================================
  // reference domain declarations
  olisr_mode_t mode_q;
  logic [31:0] rst_cnt_q, tick_cnt_q;
  logic        clr_s1_q, clr_s2_q, clr_s3_q;
  logic [7:0]  sen_s1_q, sen_s2_q;
  logic        osc_s1_q, osc_s2_q, half_s1_q, half_s2_q;
  logic        req_s1_q, req_s2_q, req_s3_q;
  logic [7:0]  stat_q, ctrl_q, lamp_q, imp_q, prev_q, new_q, en_q;
  logic [4:0]  al_h_q, wt_h_q;
  logic [5:0]  al_m_q, al_s_q, wt_m_q, wt_s_q;
  logic        chi_q, run_q, ack_tgl_q;
  logic [7:0]  rsp_dat_q, rd_byte, st_set, mask, chg_v;
  logic        clr_rise, clr_fall, req_evt, rd_evt, wr_evt;
  logic        rd_stat, rd_new, tick, al_en, alm_hit, osc_recov;
  // ==========================================================
  // link domain declarations
  olisr_link_t st_q;
  logic        lrst_s1_q, lrst_s2_q, run_s1_q, run_s2_q;
  logic        scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  logic        ack_s1_q, ack_s2_q, ack_s3_q;
  logic        req_tgl_q, req_wr_q, req_wrp_q, rw_q, wrp_q;
  logic [3:0]  req_adr_q, ptr_q, cnt_q;
  logic [7:0]  req_dat_q, sh_q, tx_q, txsh_q;
  logic        scl_r, scl_f, start, stop;

  // one step of a wrapping time counter
  function automatic logic [5:0] olisr_inc(input logic [5:0] v, input logic [5:0] last);
    olisr_inc = (v == last) ? 6'h00 : 6'(v + 6'h01);
  endfunction : olisr_inc

  // pin and handshake synchronisers, reference side
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      clr_s1_q <= 1'b0;
      clr_s2_q <= 1'b0;
      clr_s3_q <= 1'b0;
    end else begin
      clr_s1_q <= SYSTEM_CLEAR_N_I;
      clr_s2_q <= clr_s1_q;
      clr_s3_q <= clr_s2_q;
    end
  end
  always_ff @(posedge REF_CLK_I) begin
    sen_s1_q  <= SENSE_IN_I;
    sen_s2_q  <= sen_s1_q;
    osc_s1_q  <= OSC_FAIL_I;
    osc_s2_q  <= osc_s1_q;
    half_s1_q <= HALF_SUPPLY_I;
    half_s2_q <= half_s1_q;
    req_s1_q  <= req_tgl_q;
    req_s2_q  <= req_s1_q;
    req_s3_q  <= req_s2_q;
  end

  // event decode
  assign clr_rise  = (mode_q == M_CLEAR) && clr_s2_q;
  assign clr_fall  = clr_s3_q && !clr_s2_q;
  assign req_evt   = (req_s2_q ^ req_s3_q) && (mode_q == M_RUN);
  assign rd_evt    = req_evt && !req_wr_q;
  assign wr_evt    = req_evt && req_wr_q;
  assign rd_stat   = rd_evt && (req_adr_q == `OLISR_RI_STAT);
  assign rd_new    = rd_evt && (req_adr_q == `OLISR_RI_NEW);
  assign osc_recov = (mode_q == M_OSCF) && !osc_s2_q;
  assign mask      = {ctrl_q[7:4], 4'h0};
  assign chg_v     = en_q & ~mask & (sen_s2_q ^ prev_q);
  assign tick      = (tick_cnt_q == 32'(TICK_CYC - 1));
  assign al_en     = (al_h_q <= `OLISR_HR_LAST) && (al_m_q <= `OLISR_MS_LAST)
                     && (al_s_q <= `OLISR_MS_LAST);
  assign alm_hit   = tick && al_en && ({al_h_q, al_m_q, al_s_q} == {wt_h_q, wt_m_q, wt_s_q});
  assign st_set    = {(|chg_v) && !rd_new, half_s2_q, osc_recov, LINK_MISS_EVT_I,
                      alm_hit, LV_TIMER_EVT_I, 1'b0, WDOG_RST_EVT_I};

  // operating mode sequence
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      mode_q    <= M_CLEAR;
      rst_cnt_q <= 32'h0;
    end else if (!clr_s2_q) begin
      mode_q    <= M_CLEAR;
      rst_cnt_q <= 32'h0;
    end else begin
      unique case (mode_q)
        M_CLEAR: begin
          mode_q <= M_PULSE;
        end
        M_PULSE: begin
          if (osc_s2_q) begin
            mode_q <= M_OSCF;
          end else if (rst_cnt_q == 32'(RST_CYC - 1)) begin
            mode_q <= M_RUN;
          end else begin
            rst_cnt_q <= rst_cnt_q + 32'h1;
          end
        end
        M_RUN: begin
          if (osc_s2_q) begin
            mode_q <= M_OSCF;
          end
        end
        M_OSCF: begin
          if (!osc_s2_q) begin
            mode_q    <= M_PULSE;
            rst_cnt_q <= 32'h0;
          end
        end
      endcase
    end
  end
  always_ff @(posedge REF_CLK_I) begin
    run_q <= !SYS_RST_I && (mode_q == M_RUN);
  end

  // pin levels per mode
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      RESET_PULSE_OUT_O    <= 1'b1;
      RESET_PULSE_OUT_OE_O <= 1'b1;
      POWER_HOLD_O         <= 1'b0;
      LAMP_OUT_O           <= 1'b0;
      CHANGE_FLAG_N_O      <= 1'b1;
      CHANGE_FLAG_N_OE_O   <= 1'b0;
    end else begin
      RESET_PULSE_OUT_O <= 1'b1;
      unique case (mode_q)
        M_CLEAR: begin
          RESET_PULSE_OUT_OE_O <= 1'b1;
          POWER_HOLD_O         <= 1'b0;
          LAMP_OUT_O           <= 1'b0;
          CHANGE_FLAG_N_O      <= 1'b1;
          CHANGE_FLAG_N_OE_O   <= 1'b0;
        end
        M_PULSE: begin
          RESET_PULSE_OUT_OE_O <= 1'b1;
          POWER_HOLD_O         <= ctrl_q[`OLISR_CTRL_PWR];
          LAMP_OUT_O           <= 1'b0;
          CHANGE_FLAG_N_O      <= 1'b0;
          CHANGE_FLAG_N_OE_O   <= 1'b1;
        end
        M_RUN: begin
          RESET_PULSE_OUT_OE_O <= 1'b0;
          POWER_HOLD_O         <= ctrl_q[`OLISR_CTRL_PWR];
          LAMP_OUT_O           <= lamp_q[`OLISR_LAMP_HI] && !lamp_q[`OLISR_LAMP_FN];
          CHANGE_FLAG_N_O      <= !chi_q;
          CHANGE_FLAG_N_OE_O   <= 1'b1;
        end
        M_OSCF: begin
          RESET_PULSE_OUT_OE_O <= 1'b0;
          POWER_HOLD_O         <= 1'b0;
          LAMP_OUT_O           <= 1'b0;
          CHANGE_FLAG_N_O      <= 1'b0;
          CHANGE_FLAG_N_OE_O   <= 1'b1;
        end
      endcase
    end
  end

  // event status, set wins over the read clear
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I || clr_rise) begin
      stat_q <= `OLISR_DEF_STAT;
      chi_q  <= 1'b1;
    end else begin
      stat_q <= (rd_stat ? 8'h00 : stat_q) | st_set;
      chi_q  <= (chi_q && !rd_stat) || (|st_set);
    end
  end

  // previous and latched input registers
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      prev_q <= 8'h00;
      new_q  <= 8'h00;
      en_q   <= 8'hFF;
    end else begin
      if (clr_fall) begin
        prev_q <= sen_s2_q;
      end
      if (clr_rise) begin
        new_q <= sen_s2_q;
        en_q  <= 8'hFF;
      end else if (mode_q != M_CLEAR) begin
        for (int i = 0; i < 8; i++) begin
          if (mask[i]) begin
            new_q[i]  <= sen_s2_q[i];
            prev_q[i] <= sen_s2_q[i];
            en_q[i]   <= 1'b1;
          end else if (rd_new) begin
            prev_q[i] <= new_q[i];
            en_q[i]   <= 1'b1;
          end else if (chg_v[i]) begin
            new_q[i] <= sen_s2_q[i];
            en_q[i]  <= 1'b0;
          end
        end
      end
    end
  end

  // one second timebase
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I || clr_rise || tick) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  // control, lamp, impedance and time registers
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I || clr_rise) begin
      ctrl_q <= `OLISR_DEF_CTRL;
      lamp_q <= `OLISR_DEF_LAMP;
      imp_q  <= `OLISR_DEF_IMP;
      al_h_q <= `OLISR_DEF_AL_H;
      al_m_q <= `OLISR_DEF_AL_X;
      al_s_q <= `OLISR_DEF_AL_X;
      wt_h_q <= 5'h00;
      wt_m_q <= 6'h00;
      wt_s_q <= 6'h00;
    end else if (wr_evt) begin
      case (req_adr_q)
        `OLISR_WA_CTRL: ctrl_q <= req_dat_q;
        `OLISR_WA_LAMP: lamp_q <= req_dat_q;
        `OLISR_WA_AL_H: al_h_q <= req_dat_q[4:0];
        `OLISR_WA_AL_M: al_m_q <= req_dat_q[5:0];
        `OLISR_WA_AL_S: al_s_q <= req_dat_q[5:0];
        `OLISR_WA_WT_H: wt_h_q <= req_dat_q[4:0];
        `OLISR_WA_WT_M: wt_m_q <= req_dat_q[5:0];
        `OLISR_WA_WT_S: wt_s_q <= req_dat_q[5:0];
        `OLISR_WA_IMP:  imp_q  <= req_dat_q;
        default: ;
      endcase
    end else if (tick) begin
      wt_s_q <= olisr_inc(wt_s_q, `OLISR_MS_LAST);
      if (wt_s_q == `OLISR_MS_LAST) begin
        wt_m_q <= olisr_inc(wt_m_q, `OLISR_MS_LAST);
        if (wt_m_q == `OLISR_MS_LAST) begin
          wt_h_q <= 5'(olisr_inc({1'b0, wt_h_q}, {1'b0, `OLISR_HR_LAST}));
        end
      end
    end
  end

  // read byte select in sequence order
  always_comb begin
    case (req_adr_q)
      `OLISR_RI_STAT: rd_byte = stat_q;
      `OLISR_RI_PREV: rd_byte = prev_q;
      `OLISR_RI_NEW:  rd_byte = new_q;
      4'h3:           rd_byte = {3'h0, al_h_q};
      4'h4:           rd_byte = {2'h0, al_m_q};
      4'h5:           rd_byte = {2'h0, al_s_q};
      4'h6:           rd_byte = {3'h0, wt_h_q};
      4'h7:           rd_byte = {2'h0, wt_m_q};
      4'h8:           rd_byte = {2'h0, wt_s_q};
      default:        rd_byte = 8'h00;
    endcase
    if (req_wrp_q) begin
      rd_byte[7:6] = 2'h0;
    end
  end

  // answer to each link request
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      ack_tgl_q <= 1'b0;
      rsp_dat_q <= 8'h00;
    end else if (req_s2_q ^ req_s3_q) begin
      ack_tgl_q <= !ack_tgl_q;
      rsp_dat_q <= rd_byte;
    end
  end

  // ==========================================================
  // link domain synchronisers
  always_ff @(posedge LINK_CLK_I) begin
    lrst_s1_q <= SYS_RST_I;
    lrst_s2_q <= lrst_s1_q;
    run_s1_q  <= run_q;
    run_s2_q  <= run_s1_q;
    scl_s1_q  <= SCL_I;
    scl_s2_q  <= scl_s1_q;
    scl_s3_q  <= scl_s2_q;
    sda_s1_q  <= SDA_I;
    sda_s2_q  <= sda_s1_q;
    sda_s3_q  <= sda_s2_q;
    ack_s1_q  <= ack_tgl_q;
    ack_s2_q  <= ack_s1_q;
    ack_s3_q  <= ack_s2_q;
  end

  // bus conditions
  assign scl_r = scl_s2_q && !scl_s3_q;
  assign scl_f = !scl_s2_q && scl_s3_q;
  assign start = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q;
  assign stop  = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;

  // byte returned by the register side
  always_ff @(posedge LINK_CLK_I) begin
    if (lrst_s2_q) begin
      tx_q <= 8'h00;
    end else if (ack_s2_q ^ ack_s3_q) begin
      tx_q <= rsp_dat_q;
    end
  end

  // serial slave protocol
  always_ff @(posedge LINK_CLK_I) begin
    SDA_O <= 1'b0;
    if (lrst_s2_q || !run_s2_q || stop) begin
      st_q     <= L_IDLE;
      SDA_OE_O <= 1'b0;
      cnt_q    <= 4'h0;
      if (lrst_s2_q) begin
        sh_q      <= 8'h00;
        txsh_q    <= 8'h00;
        ptr_q     <= 4'h0;
        rw_q      <= 1'b0;
        wrp_q     <= 1'b0;
        req_tgl_q <= 1'b0;
        req_wr_q  <= 1'b0;
        req_wrp_q <= 1'b0;
        req_adr_q <= 4'h0;
        req_dat_q <= 8'h00;
      end
    end else if (start) begin
      st_q     <= L_ADDR;
      SDA_OE_O <= 1'b0;
      cnt_q    <= 4'h0;
    end else begin
      unique case (st_q)
        L_IDLE, L_IGN: ;
        L_ADDR, L_WADR, L_WDAT: begin
          if (scl_r) begin
            sh_q  <= {sh_q[6:0], sda_s2_q};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_f && cnt_q == 4'h8) begin
            cnt_q <= 4'h0;
            if (st_q == L_ADDR) begin
              if (sh_q[7:1] == DEV_SEL) begin
                st_q     <= L_AACK;
                SDA_OE_O <= 1'b1;
                rw_q     <= sh_q[0];
                if (sh_q[0]) begin
                  ptr_q     <= `OLISR_RI_STAT;
                  wrp_q     <= 1'b0;
                  req_tgl_q <= !req_tgl_q;
                  req_wr_q  <= 1'b0;
                  req_wrp_q <= 1'b0;
                  req_adr_q <= `OLISR_RI_STAT;
                end
              end else begin
                st_q <= L_IDLE;
              end
            end else if (st_q == L_WADR) begin
              if (sh_q <= `OLISR_WA_LAST) begin
                st_q     <= L_DACK;
                SDA_OE_O <= 1'b1;
                ptr_q    <= sh_q[3:0];
              end else begin
                st_q <= L_IGN;
              end
            end else begin
              st_q      <= L_DACK;
              SDA_OE_O  <= 1'b1;
              ptr_q     <= ptr_q + 4'h1;
              req_tgl_q <= !req_tgl_q;
              req_wr_q  <= 1'b1;
              req_adr_q <= ptr_q;
              req_dat_q <= sh_q;
            end
          end
        end
        L_AACK: begin
          if (scl_f) begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              st_q     <= L_RDAT;
              SDA_OE_O <= !tx_q[7];
              txsh_q   <= {tx_q[6:0], 1'b0};
              cnt_q    <= 4'h1;
            end else begin
              st_q     <= L_WADR;
              SDA_OE_O <= 1'b0;
            end
          end
        end
        L_DACK: begin
          if (scl_f) begin
            st_q     <= L_WDAT;
            SDA_OE_O <= 1'b0;
          end
        end
        L_RDAT: begin
          if (scl_f) begin
            if (cnt_q == 4'h8) begin
              st_q     <= L_RACK;
              SDA_OE_O <= 1'b0;
            end else begin
              SDA_OE_O <= !txsh_q[7];
              txsh_q   <= {txsh_q[6:0], 1'b0};
              cnt_q    <= cnt_q + 4'h1;
            end
          end
        end
        L_RACK: begin
          if (scl_r) begin
            if (!sda_s2_q) begin
              st_q      <= L_AACK;
              ptr_q     <= (ptr_q == `OLISR_RI_LAST) ? 4'h0 : ptr_q + 4'h1;
              wrp_q     <= wrp_q || (ptr_q == `OLISR_RI_LAST);
              req_tgl_q <= !req_tgl_q;
              req_wr_q  <= 1'b0;
              req_wrp_q <= wrp_q || (ptr_q == `OLISR_RI_LAST);
              req_adr_q <= (ptr_q == `OLISR_RI_LAST) ? 4'h0 : ptr_q + 4'h1;
            end else begin
              st_q <= L_IGN;
            end
          end
        end
      endcase
    end
  end
endmodule : olisr_top
`default_nettype wire

// *** olisr_checker.sv ***
// Purpose: port assertions for olisr_top
// Assumes: all checks sampled on REF_CLK_I
// Notes  : bound to olisr_top from tb_top
`timescale 1ns/10ps
`default_nettype none
module olisr_checker #(
  parameter int unsigned RST_CYC = 50
) (
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic SYSTEM_CLEAR_N_I,
  input wire logic OSC_FAIL_I,
  input wire logic SDA_OE_O,
  input wire logic RESET_PULSE_OUT_O,
  input wire logic RESET_PULSE_OUT_OE_O,
  input wire logic POWER_HOLD_O,
  input wire logic LAMP_OUT_O,
  input wire logic CHANGE_FLAG_N_O,
  input wire logic CHANGE_FLAG_N_OE_O
);
  localparam int PW_LO = int'(RST_CYC) - 2;
  localparam int PW_HI = int'(RST_CYC) + 2;
  // ==========
  // pin levels per mode
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  clear_low_pins_a: assert property (
    !SYSTEM_CLEAR_N_I [*6] |-> RESET_PULSE_OUT_OE_O && !POWER_HOLD_O && !LAMP_OUT_O && !CHANGE_FLAG_N_OE_O)
    else $error("pins wrong while clear low");
  clear_fall_a: assert property (
    $fell(SYSTEM_CLEAR_N_I) && !OSC_FAIL_I |-> ##[3:8] RESET_PULSE_OUT_OE_O && !CHANGE_FLAG_N_OE_O)
    else $error("clear fall not seen at pins");
  pulse_pins_a: assert property (
    SYSTEM_CLEAR_N_I && !OSC_FAIL_I && RESET_PULSE_OUT_OE_O [*8]
    |-> CHANGE_FLAG_N_OE_O && !CHANGE_FLAG_N_O && POWER_HOLD_O && !LAMP_OUT_O)
    else $error("pins wrong during pulse");
  pulse_width_a: assert property (
    $rose(CHANGE_FLAG_N_OE_O) |-> ##[PW_LO:PW_HI] $fell(RESET_PULSE_OUT_OE_O))
    else $error("reset pulse length wrong");
  pulse_level_a: assert property (
    RESET_PULSE_OUT_OE_O |-> RESET_PULSE_OUT_O)
    else $error("reset pulse driven low");
  osc_fail_pins_a: assert property (
    OSC_FAIL_I [*7] |-> !RESET_PULSE_OUT_OE_O && !POWER_HOLD_O && !LAMP_OUT_O
    && CHANGE_FLAG_N_OE_O && !CHANGE_FLAG_N_O && !SDA_OE_O)
    else $error("pins wrong in oscillator failure");
  osc_recover_a: assert property (
    $fell(OSC_FAIL_I) |-> ##[3:8] RESET_PULSE_OUT_OE_O)
    else $error("no pulse after oscillator recovery");
  sda_run_only_a: assert property (
    SDA_OE_O |-> !RESET_PULSE_OUT_OE_O && SYSTEM_CLEAR_N_I)
    else $error("data line driven outside run");
endmodule : olisr_checker
`default_nettype wire

// *** olisr_host.sv ***
// Purpose: bus master model for the olisr serial port
// Assumes: open drain bus with pull-up resolved in the bench
// Notes  : clock stands high between frames
`timescale 1ns/10ps
`default_nettype none
module olisr_host (
  output var  logic scl_o,
  output var  logic sda_low_o,
  input  wire logic sda_i
);
  localparam int Q = 100; // quarter bit in ns, clock low 200 ns
  // ==========
  // idle: both lines released
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end
  // start: data falls while clock high
  task start_cond();
    sda_low_o = 1'b1;
    #Q scl_o = 1'b0;
    #Q;
  endtask : start_cond
  // stop: data rises while clock high
  task stop_cond();
    sda_low_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b0;
    #(2 * Q);
  endtask : stop_cond
  // send a byte msb first, then sample the answer
  task wr_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low_o = ~b[i];
      #Q scl_o = 1'b1;
      #(2 * Q) scl_o = 1'b0;
      #Q;
    end
    sda_low_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q ack = ~sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask : wr_byte
  // receive a byte, then acknowledge or not
  task rd_byte(input logic mack, output logic [7:0] b);
    sda_low_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #Q scl_o = 1'b1;
      #Q b[i] = sda_i;
      #Q scl_o = 1'b0;
      #Q;
    end
    sda_low_o = mack; // withheld on the last byte wanted
    #Q scl_o = 1'b1;
    #(2 * Q) scl_o = 1'b0;
    #Q sda_low_o = 1'b0;
  endtask : rd_byte
endmodule : olisr_host
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for olisr_top
// Assumes: short reset pulse, slow watch tick
// Notes  : reference values kept in mdl, index = read position
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int unsigned RST_CYC = 50;
  localparam logic [6:0]  SEL     = 7'h2A; // arbitrary select code
  logic       ref_clk, link_clk, sys_rst, clear_n, osc_fail, half_sup, wdog, miss, lvt;
  logic       scl, host_low, sda_oe, rp_oe, chi_n, ack;
  logic [7:0] sense, s0, got;
  wire  logic sda = ~(sda_oe | host_low); // pull-up when released
  int         mismatches, check_count, v, mdl[9];
  olisr_top #(.DEV_SEL(SEL), .RST_CYC(RST_CYC), .TICK_CYC(1000000)) DUT (
    .REF_CLK_I(ref_clk), .SYS_RST_I(sys_rst), .LINK_CLK_I(link_clk), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(), .SDA_OE_O(sda_oe), .SYSTEM_CLEAR_N_I(clear_n), .SENSE_IN_I(sense), .OSC_FAIL_I(osc_fail),
    .HALF_SUPPLY_I(half_sup), .WDOG_RST_EVT_I(wdog), .LINK_MISS_EVT_I(miss), .LV_TIMER_EVT_I(lvt),
    .RESET_PULSE_OUT_O(), .RESET_PULSE_OUT_OE_O(rp_oe), .POWER_HOLD_O(), .LAMP_OUT_O(),
    .CHANGE_FLAG_N_O(chi_n), .CHANGE_FLAG_N_OE_O());
  olisr_host u_host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda));
  // ==========
  // clocks
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // ==========
  // helpers
  task step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task end_of_test();
    $display("mismatches=%0d check_count=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  // bounded wait for the end of the reset pulse
  task automatic wait_run();
    int k;
    step(10);
    for (k = 0; k < 400 && rp_oe !== 1'b0; k++) step(1);
    if (k == 400) begin
      mismatches++;
      end_of_test();
    end
    step(10);
  endtask : wait_run
  task wr_chk(input logic [7:0] b, input logic ea);
    u_host.wr_byte(b, ack);
    chk({7'h00, ack}, {7'h00, ea});
  endtask : wr_chk
  task sel(input logic rd, input logic ea);
    u_host.start_cond();
    wr_chk({SEL, rd}, ea);
  endtask : sel
  // sequential read compared with the model
  task automatic rd_seq(input int n);
    logic [7:0] e;
    sel(1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      e = 8'(mdl[i % 9]);
      if (i >= 9) e = e & 8'h3F;
      u_host.rd_byte(i < n - 1, got);
      chk(got, e);
      if (i % 9 == 0) mdl[0] = 0;
      if (i % 9 == 2) mdl[1] = mdl[2];
    end
    u_host.stop_cond();
  endtask : rd_seq
  // ==========
  // main sequence
  initial begin
    {sys_rst, clear_n} = 2'b11;
    {osc_fail, half_sup, wdog, miss, lvt} = 5'h00;
    mismatches  = 0;
    check_count = 0;
    v = $urandom(78);
    s0 = 8'($urandom % 256);
    sense = s0;
    step(2);
    sys_rst = 1'b0;
    wait_run();
    clear_n = 1'b0;
    step(8);
    sel(1'b0, 1'b0); // ignored outside run
    u_host.stop_cond();
    clear_n = 1'b1;
    mdl = '{2, s0, s0, 8'h1F, 8'h3F, 8'h3F, 0, 0, 0};
    wait_run();
    chk({7'h00, chi_n}, 8'h00);
    rd_seq(12);
    chk({7'h00, chi_n}, 8'h01);
    sel(1'b0, 1'b1);
    wr_chk(8'h02, 1'b1);
    for (int k = 0; k < 6; k++) begin
      v = (k < 3) ? $urandom % 256 : $urandom % ((k == 3) ? 24 : 60);
      mdl[3 + k] = v & ((k % 3 == 0) ? 8'h1F : 8'h3F);
      wr_chk(8'(v), 1'b1);
    end
    u_host.stop_cond();
    sel(1'b0, 1'b1);
    wr_chk(8'h09, 1'b0);
    wr_chk(8'h5A, 1'b0);
    u_host.stop_cond();
    rd_seq(9);
    sense = s0 ^ 8'h0F;
    step(20);
    chk({7'h00, chi_n}, 8'h00);
    mdl[0] = 8'h80;
    mdl[2] = s0 ^ 8'h0F;
    rd_seq(3);
    rd_seq(3);
    {wdog, miss, lvt, half_sup} = 4'hF;
    step(1);
    {wdog, miss, lvt} = 3'h0;
    step(20);
    half_sup = 1'b0;
    wait_run();
    mdl[0] = 8'h55;
    rd_seq(1);
    rd_seq(1);
    osc_fail = 1'b1;
    step(20);
    osc_fail = 1'b0;
    wait_run();
    mdl[0] = 8'h20;
    rd_seq(1);
    end_of_test();
  end
endmodule : tb_top
bind olisr_top olisr_checker #(.RST_CYC(RST_CYC)) u_chk (
  .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .SYSTEM_CLEAR_N_I(SYSTEM_CLEAR_N_I),
  .OSC_FAIL_I(OSC_FAIL_I), .SDA_OE_O(SDA_OE_O), .RESET_PULSE_OUT_O(RESET_PULSE_OUT_O),
  .RESET_PULSE_OUT_OE_O(RESET_PULSE_OUT_OE_O), .POWER_HOLD_O(POWER_HOLD_O), .LAMP_OUT_O(LAMP_OUT_O),
  .CHANGE_FLAG_N_O(CHANGE_FLAG_N_O), .CHANGE_FLAG_N_OE_O(CHANGE_FLAG_N_OE_O));
`default_nettype wire
